// ---- verilog/bridge_window_pkg.sv ----
// shared constants, field layouts and carriers of the bridge window register bank
package bridge_window_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_MEM_WINDOW = 8'h20;
  localparam logic [7:0] OFS_PREFETCH_WINDOW = 8'h24;
  localparam logic [7:0] OFS_PREFETCH_START_HIGH = 8'h28;
  localparam logic [7:0] OFS_PREFETCH_END_HIGH = 8'h2c;
  localparam logic [7:0] OFS_IO_WINDOW_HIGH = 8'h30;
  localparam logic [7:0] OFS_CAPABILITY_HEAD = 8'h34;
  localparam logic [7:0] OFS_OPTION_ROM = 8'h38;
  localparam logic [7:0] OFS_INTR_BRIDGE_CTRL = 8'h3c;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'hf0;
  localparam logic [7:0] OFS_EVENT_CLEAR = 8'hf4;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'hf8;

  // ****************************************
  // fixed read values and reset values
  // ****************************************
  localparam logic [3:0] ADDR64_CAPABLE = 4'h1;
  localparam logic [7:0] CAP_HEAD_NORMAL = 8'h80;
  localparam logic [7:0] CAP_HEAD_LEGACY = 8'h90;
  localparam logic [7:0] INTR_PIN_VALUE = 8'h01;
  localparam logic [7:0] INTR_ROUTING_RESET = 8'h00;
  localparam logic [11:0] WINDOW_FIELD_RESET = 12'h000;
  localparam logic [15:0] IO_HIGH_RESET = 16'h0000;
  localparam logic [31:0] DWORD_RESET = 32'h00000000;

  // ****************************************
  // bridge control bit positions
  // ****************************************
  localparam int BC_PARITY_RESPONSE = 16;
  localparam int BC_SERR_FORWARD = 17;
  localparam int BC_ISA_MODE = 18;
  localparam int BC_VGA_ENABLE = 19;
  localparam int BC_VGA_16BIT = 20;
  localparam logic [4:0] BRIDGE_CTRL_RESET = 5'h00;

  // ****************************************
  // event bits of status, clear and enable
  // ****************************************
  localparam int EV_PARITY = 0;
  localparam int EV_SERR = 1;
  localparam int EV_UPSTREAM = 2;
  localparam int EV_WIDTH = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  // ****************************************
  // decode request carrier
  // ****************************************
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [63:0] addr;
  } fwd_req_s;

endpackage

// ---- verilog/bridge_window_config_regs.sv ----
// bridge window register bank with forwarding decode and error events
`timescale 1ns/10ps

module bridge_window_config_regs (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic LEGACY_MODE,
  input wire logic SEC_PARITY_ERR,
  input wire logic SYSTEM_ERROR_PIN_N,
  input wire logic IO_ENABLE,
  input wire logic MEM_ENABLE,
  input wire logic [3:0] IO_BASE_NIBBLE,
  input wire logic [3:0] IO_LIMIT_NIBBLE,
  input wire logic [11:0] MEM_BASE_FIELD,
  input wire bridge_window_pkg::fwd_req_s FWD_REQ,
  output logic FWD_DONE,
  output logic FWD_DOWNSTREAM,
  output logic PARITY_RESPOND,
  output logic ERR_MSG_REQ,
  output logic IRQ
);

  // ****************************************
  // register map, one dword per offset
  // ****************************************
  // 20h [31:20] memory window end; [19:0] read zero
  // 24h [31:20] prefetch end; [19:16] and [3:0] read 0001; [15:4] prefetch start
  // 28h prefetch start, address bits 63:32
  // 2ch prefetch end, address bits 63:32
  // 30h [31:16] io end bits 31:16; [15:0] io start bits 31:16
  // 34h capability head, 80h, or 90h while legacy mode is seen
  // 38h option rom address, always zero, writes dropped
  // 3ch [20:16] bridge control; [15:8] pin byte 01h; [7:0] routing byte
  // f0h event status, sticky, read only
  // f4h event clear, ones clear, reads zero
  // f8h event enable, same layout as status
  // every other offset reads zero and drops writes
  // the low half of 20h and bridge bits 21 and up belong to neighbouring banks,
  // so a wider decoder must merge their read data with ours

  // ****************************************
  // register state
  // ****************************************
  logic [11:0] mem_end_q;
  logic [11:0] pf_start_q;
  logic [11:0] pf_end_q;
  logic [31:0] pf_start_hi_q;
  logic [31:0] pf_end_hi_q;
  logic [15:0] io_start_hi_q;
  logic [15:0] io_end_hi_q;
  logic [7:0] intr_routing_q;
  logic [4:0] bridge_ctrl_q;
  logic [2:0] ev_status_q;
  logic [2:0] ev_status_d;
  logic [2:0] ev_enable_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // synchroniser chains for pins from outside the clock domain
  logic legacy_s1_q;
  logic legacy_s2_q;
  logic parity_s1_q;
  logic parity_s2_q;
  logic parity_s3_q;
  logic serr_s1_q;
  logic serr_s2_q;
  logic serr_s3_q;

  // registered outputs
  logic fwd_done_q;
  logic fwd_down_q;
  logic parity_resp_q;
  logic err_msg_q;
  logic irq_q;

  // ****************************************
  // helpers
  // ****************************************
  // inclusive window check, shared by the io, memory, prefetch and vga frame buffer decodes
  // unsigned compare, so a start of zero is a valid lower bound
  function automatic logic in_window(input logic [63:0] a, input logic [63:0] lo,
                                     input logic [63:0] hi);
    in_window = (a >= lo) && (a <= hi);
  endfunction

  // write a selected dword only when the strobe and the offset agree
  // all eight address bits are compared, so no offset aliases another
  function automatic logic hit(input logic strobe, input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = strobe && (a == ofs);
  endfunction

  // ****************************************
  // write decode
  // ****************************************
  // the bus carries no byte enables, so every write is a whole dword
  // a write is taken in its strobe cycle and lands at that edge; the bank
  // never stalls the host, so there is no ready or wait state anywhere
  wire wr_mem = hit(WR, ADDR, bridge_window_pkg::OFS_MEM_WINDOW);
  wire wr_pf = hit(WR, ADDR, bridge_window_pkg::OFS_PREFETCH_WINDOW);
  wire wr_pf_start_hi = hit(WR, ADDR, bridge_window_pkg::OFS_PREFETCH_START_HIGH);
  wire wr_pf_end_hi = hit(WR, ADDR, bridge_window_pkg::OFS_PREFETCH_END_HIGH);
  wire wr_io_hi = hit(WR, ADDR, bridge_window_pkg::OFS_IO_WINDOW_HIGH);
  wire wr_intr_bc = hit(WR, ADDR, bridge_window_pkg::OFS_INTR_BRIDGE_CTRL);
  wire wr_ev_clear = hit(WR, ADDR, bridge_window_pkg::OFS_EVENT_CLEAR);
  wire wr_ev_enable = hit(WR, ADDR, bridge_window_pkg::OFS_EVENT_ENABLE);

  // ****************************************
  // window registers
  // ****************************************
  // writes to the capability head and option rom offsets fall through untouched
  // fixed read-only bits are not stored at all; they are tied in the read mux
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mem_end_q <= bridge_window_pkg::WINDOW_FIELD_RESET;
      pf_start_q <= bridge_window_pkg::WINDOW_FIELD_RESET;
      pf_end_q <= bridge_window_pkg::WINDOW_FIELD_RESET;
      pf_start_hi_q <= bridge_window_pkg::DWORD_RESET;
      pf_end_hi_q <= bridge_window_pkg::DWORD_RESET;
      io_start_hi_q <= bridge_window_pkg::IO_HIGH_RESET;
      io_end_hi_q <= bridge_window_pkg::IO_HIGH_RESET;
    end else begin
      if (wr_mem) begin
        mem_end_q <= WDATA[31:20];
      end
      if (wr_pf) begin
        pf_start_q <= WDATA[15:4];
        pf_end_q <= WDATA[31:20];
      end
      if (wr_pf_start_hi) begin
        pf_start_hi_q <= WDATA;
      end
      if (wr_pf_end_hi) begin
        pf_end_hi_q <= WDATA;
      end
      if (wr_io_hi) begin
        io_start_hi_q <= WDATA[15:0];
        io_end_hi_q <= WDATA[31:16];
      end
    end
  end

  // interrupt routing byte and the bridge control bits held here
  // the routing byte is only stored for software; nothing here decodes it
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      intr_routing_q <= bridge_window_pkg::INTR_ROUTING_RESET;
      bridge_ctrl_q <= bridge_window_pkg::BRIDGE_CTRL_RESET;
    end else if (wr_intr_bc) begin
      intr_routing_q <= WDATA[7:0];
      bridge_ctrl_q <= WDATA[bridge_window_pkg::BC_VGA_16BIT:bridge_window_pkg::BC_PARITY_RESPONSE];
    end
  end

  // named control bits; only 20:16 live here, so each index is rebased by 16
  // and all five leave reset at zero: no gating, no vga, no isa alias
  wire bc_parity = bridge_ctrl_q[bridge_window_pkg::BC_PARITY_RESPONSE - 16];
  wire bc_serr = bridge_ctrl_q[bridge_window_pkg::BC_SERR_FORWARD - 16];
  wire bc_isa = bridge_ctrl_q[bridge_window_pkg::BC_ISA_MODE - 16];
  wire bc_vga = bridge_ctrl_q[bridge_window_pkg::BC_VGA_ENABLE - 16];
  wire bc_vga16 = bridge_ctrl_q[bridge_window_pkg::BC_VGA_16BIT - 16];

  // ****************************************
  // pin synchronisers
  // ****************************************
  // stage one feeds stage two only; edge detection looks at later stages
  // the error pins are slow levels: a pulse shorter than one clock may be
  // missed, which was traded for a plain chain with no pulse stretcher
  // the system error chain idles high so its release from reset is no edge
  // legacy mode is a level and needs no third stage
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      legacy_s1_q <= 1'b0;
      legacy_s2_q <= 1'b0;
      parity_s1_q <= 1'b0;
      parity_s2_q <= 1'b0;
      parity_s3_q <= 1'b0;
      serr_s1_q <= 1'b1;
      serr_s2_q <= 1'b1;
      serr_s3_q <= 1'b1;
    end else begin
      legacy_s1_q <= LEGACY_MODE;
      legacy_s2_q <= legacy_s1_q;
      parity_s1_q <= SEC_PARITY_ERR;
      parity_s2_q <= parity_s1_q;
      parity_s3_q <= parity_s2_q;
      serr_s1_q <= SYSTEM_ERROR_PIN_N;
      serr_s2_q <= serr_s1_q;
      serr_s3_q <= serr_s2_q;
    end
  end

  // ****************************************
  // error handling
  // ****************************************
  // a parity error is acted on only at its rising edge and only when enabled
  // one response per edge however long the pin stays up; with the bit clear
  // the edge is dropped, not held back, so setting the bit later acts on nothing
  wire parity_edge = parity_s2_q && !parity_s3_q;
  wire parity_take = parity_edge && bc_parity;
  // a falling edge on the active-low system error pin asks for one message
  wire serr_edge = !serr_s2_q && serr_s3_q;
  wire serr_take = serr_edge && bc_serr;

  // ****************************************
  // forwarding decode
  // ****************************************
  // limits imply all-ones low bits so a window covers its whole last block
  // limitations a user must know:
  // the lower io nibbles and the memory start field come in as ports
  // the io window is 32 bits wide, its upper dword is forced to zero
  // a start above the end gives an empty window that forwards nothing
  // plain and prefetch memory windows may overlap; either hit forwards
  // addresses are unsigned; nothing wraps past the top of the space
  wire [63:0] req_addr = FWD_REQ.addr;
  wire [63:0] io_lo = {32'h00000000, io_start_hi_q, IO_BASE_NIBBLE, 12'h000};
  wire [63:0] io_hi = {32'h00000000, io_end_hi_q, IO_LIMIT_NIBBLE, 12'hfff};
  wire [63:0] mem_lo = {32'h00000000, MEM_BASE_FIELD, 20'h00000};
  wire [63:0] mem_hi = {32'h00000000, mem_end_q, 20'hfffff};
  wire [63:0] pf_lo = {pf_start_hi_q, pf_start_q, 20'h00000};
  wire [63:0] pf_hi = {pf_end_hi_q, pf_end_q, 20'hfffff};

  wire io_win_hit = in_window(req_addr, io_lo, io_hi);
  wire mem_win_hit = in_window(req_addr, mem_lo, mem_hi);
  wire pf_win_hit = in_window(req_addr, pf_lo, pf_hi);

  // isa aliasing: within the first 64KB, offsets 100h-3ffh of each 1KB block stay up
  wire isa_low64k = (req_addr[63:16] == 48'h000000000000);
  wire isa_top768 = (req_addr[9:8] != 2'h0);
  wire isa_upstream = bc_isa && isa_low64k && isa_top768;

  // vga io ports 3b0h-3bbh and 3c0h-3dfh; the 10-bit form ignores bits 31:10
  wire vga_upper_ok = bc_vga16 ? (req_addr[63:10] == 54'h0) : (req_addr[63:32] == 32'h0);
  wire vga_io_b = (req_addr[9:0] >= 10'h3b0) && (req_addr[9:0] <= 10'h3bb);
  wire vga_io_c = (req_addr[9:0] >= 10'h3c0) && (req_addr[9:0] <= 10'h3df);
  wire vga_io_hit = vga_upper_ok && (vga_io_b || vga_io_c);
  // vga frame buffer a0000h-bffffh
  wire vga_mem_hit = in_window(req_addr, 64'h00000000000a0000, 64'h00000000000bffff);

  // vga decode bypasses the isa aliasing and the windows
  // an enable that is off wins over every hit, vga included
  wire io_down = IO_ENABLE && ((bc_vga && vga_io_hit) || (io_win_hit && !isa_upstream));
  wire mem_down = MEM_ENABLE && ((bc_vga && vga_mem_hit) || mem_win_hit || pf_win_hit);
  wire fwd_down_d = FWD_REQ.is_io ? io_down : mem_down;
  // an io request that the isa alias turns back is reported as an event
  wire upstream_take = FWD_REQ.valid && FWD_REQ.is_io && io_win_hit && isa_upstream
                       && !(bc_vga && vga_io_hit);

  // one-cycle decode answer, registered
  // a request every cycle is fine: each answer stands for exactly one cycle
  // and depends only on that request, the enable and window ports and the registers at its edge
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      fwd_done_q <= 1'b0;
      fwd_down_q <= 1'b0;
      parity_resp_q <= 1'b0;
      err_msg_q <= 1'b0;
    end else begin
      fwd_done_q <= FWD_REQ.valid;
      fwd_down_q <= FWD_REQ.valid && fwd_down_d;
      parity_resp_q <= parity_take;
      err_msg_q <= serr_take;
    end
  end

  // ****************************************
  // event status, clear and enable
  // ****************************************
  // a new event in the cycle of its clear survives: set wins
  // bit 0: parity error acted on while bit 16 is set
  // bit 1: system error forwarded while bit 17 is set
  // bit 2: io request turned back upstream by the isa alias
  // clear and enable use the same layout; unused write bits are dropped
  // status survives a mask change; only a clear write drops a bit
  wire [2:0] ev_set = {upstream_take, serr_take, parity_take};
  wire [2:0] ev_clr = wr_ev_clear ? WDATA[2:0] : 3'h0;
  assign ev_status_d = (ev_status_q & ~ev_clr) | ev_set;

  // the level is worked out from next status and next enable, so it follows
  // a set, a clear or an enable write at the same edge, with no extra lag
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ev_status_q <= bridge_window_pkg::EV_RESET;
      ev_enable_q <= bridge_window_pkg::EV_RESET;
      irq_q <= 1'b0;
    end else begin
      ev_status_q <= ev_status_d;
      if (wr_ev_enable) begin
        ev_enable_q <= WDATA[2:0];
      end
      irq_q <= |(ev_status_d & (wr_ev_enable ? WDATA[2:0] : ev_enable_q));
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // fields owned by neighbouring blocks read as zero here
  wire [31:0] rd_mem = {mem_end_q, 4'h0, 16'h0000};
  wire [31:0] rd_pf = {pf_end_q, bridge_window_pkg::ADDR64_CAPABLE,
                       pf_start_q, bridge_window_pkg::ADDR64_CAPABLE};
  wire [7:0] cap_head = legacy_s2_q ? bridge_window_pkg::CAP_HEAD_LEGACY
                                    : bridge_window_pkg::CAP_HEAD_NORMAL;
  wire [31:0] rd_intr_bc = {11'h000, bridge_ctrl_q,
                            bridge_window_pkg::INTR_PIN_VALUE, intr_routing_q};

  // offset select; the write-only clear and unmapped offsets hit the default
  always_comb begin
    rdata_d = 32'h00000000;
    case (ADDR)
      bridge_window_pkg::OFS_MEM_WINDOW: rdata_d = rd_mem;
      bridge_window_pkg::OFS_PREFETCH_WINDOW: rdata_d = rd_pf;
      bridge_window_pkg::OFS_PREFETCH_START_HIGH: rdata_d = pf_start_hi_q;
      bridge_window_pkg::OFS_PREFETCH_END_HIGH: rdata_d = pf_end_hi_q;
      bridge_window_pkg::OFS_IO_WINDOW_HIGH: rdata_d = {io_end_hi_q, io_start_hi_q};
      bridge_window_pkg::OFS_CAPABILITY_HEAD: rdata_d = {24'h000000, cap_head};
      bridge_window_pkg::OFS_OPTION_ROM: rdata_d = bridge_window_pkg::DWORD_RESET;
      bridge_window_pkg::OFS_INTR_BRIDGE_CTRL: rdata_d = rd_intr_bc;
      bridge_window_pkg::OFS_EVENT_STATUS: rdata_d = {29'h00000000, ev_status_q};
      bridge_window_pkg::OFS_EVENT_ENABLE: rdata_d = {29'h00000000, ev_enable_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // read data stands only in the cycle after the strobe, zero otherwise
  // zero outside the slot lets several banks share one read bus by or-ing;
  // reads have no side effects, so a repeated read is always harmless
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= RD ? rdata_d : 32'h00000000;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a flop: decode answers one cycle after the request,
  // pin events three cycles after the pin moves, read data one cycle after
  // the strobe; none is combinational from an input
  assign RDATA = rdata_q;
  assign FWD_DONE = fwd_done_q;
  assign FWD_DOWNSTREAM = fwd_down_q;
  assign PARITY_RESPOND = parity_resp_q;
  assign ERR_MSG_REQ = err_msg_q;
  assign IRQ = irq_q;

endmodule

// ---- testbench/bridge_window_asserts.sv ----
// port-level checks of the bridge window register bank
`timescale 1ns/10ps
module bridge_window_asserts (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic SEC_PARITY_ERR,
  input wire logic SYSTEM_ERROR_PIN_N,
  input wire logic IO_ENABLE,
  input wire logic MEM_ENABLE,
  input wire bridge_window_pkg::fwd_req_s FWD_REQ,
  input wire logic FWD_DONE,
  input wire logic FWD_DOWNSTREAM,
  input wire logic PARITY_RESPOND,
  input wire logic ERR_MSG_REQ,
  input wire logic IRQ
);
  // ****************************************
  // properties on one clock
  // ****************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  // read data only in the slot after a strobe, so a stale value never leaks
  property p_rdata_idle;
    !$past(RD) |-> RDATA == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_rom;
    RD && ADDR == 8'h38 |=> RDATA == 32'h0;
  endproperty
  a_rom: assert property (p_rom) else $error("option rom not zero");
  property p_fixed;
    RD && ADDR == 8'h24 |=> RDATA[19:16] == 4'h1 && RDATA[3:0] == 4'h1;
  endproperty
  a_fixed: assert property (p_fixed) else $error("prefetch nibbles wrong");
  property p_mem_low;
    RD && ADDR == 8'h20 |=> RDATA[19:0] == 20'h0;
  endproperty
  a_mem_low: assert property (p_mem_low) else $error("memory end low bits set");
  property p_pin;
    RD && ADDR == 8'h3c |=> RDATA[15:8] == 8'h01 && RDATA[31:21] == 11'h0;
  endproperty
  a_pin: assert property (p_pin) else $error("interrupt pin byte wrong");
  // a decode with its enable off never goes downstream
  property p_gate;
    FWD_REQ.valid && !(FWD_REQ.is_io ? IO_ENABLE : MEM_ENABLE) |=> FWD_DONE && !FWD_DOWNSTREAM;
  endproperty
  a_gate: assert property (p_gate) else $error("forward with enable off");
  property p_parity;
    PARITY_RESPOND |-> $past(SEC_PARITY_ERR, 2) ##1 !PARITY_RESPOND;
  endproperty
  a_parity: assert property (p_parity) else $error("parity response unprompted");
  property p_err;
    ERR_MSG_REQ |-> !$past(SYSTEM_ERROR_PIN_N, 2) ##1 !ERR_MSG_REQ;
  endproperty
  a_err: assert property (p_err) else $error("error message unprompted");
  // sticky status keeps the level up until software writes
  property p_irq_hold;
    IRQ && !WR |=> IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
  c_parity: cover property (PARITY_RESPOND);
  c_err: cover property (ERR_MSG_REQ);
  c_down: cover property (FWD_DONE && FWD_DOWNSTREAM);
endmodule
bind bridge_window_config_regs bridge_window_asserts bridge_window_asserts_inst (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SEC_PARITY_ERR(SEC_PARITY_ERR), .SYSTEM_ERROR_PIN_N(SYSTEM_ERROR_PIN_N),
  .IO_ENABLE(IO_ENABLE), .MEM_ENABLE(MEM_ENABLE), .FWD_REQ(FWD_REQ), .FWD_DONE(FWD_DONE),
  .FWD_DOWNSTREAM(FWD_DOWNSTREAM), .PARITY_RESPOND(PARITY_RESPOND),
  .ERR_MSG_REQ(ERR_MSG_REQ), .IRQ(IRQ));

// ---- testbench/cfg_host.sv ----
// host model issuing configuration reads and writes
`timescale 1ns/10ps
module cfg_host (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // released lines flip so nothing relies on a held value
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
  // data is taken in the one cycle after the strobe
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~addr;
    #1;
    q = rdata;
  endtask
endmodule

// ---- testbench/tb_bridge_window_config_regs.sv ----
// self-checking bench of the bridge window register bank
`timescale 1ns/10ps
module tb_bridge_window_config_regs;
  logic clk_sys, resetn, wr, rd, legacy, par_err, serr_n, io_en, mem_en;
  logic done, down, par_resp, err_msg, irq;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  bridge_window_pkg::fwd_req_s req;
  int failures, checks_done, par_n, err_n;
  // ****************************************
  // tables: offsets, writable masks, fixed bits, decode cases
  // ****************************************
  logic [7:0] ofs [8] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
  logic [31:0] msk [8] = '{32'hfff00000, 32'hfff0fff0, 32'hffffffff, 32'hffffffff,
    32'hffffffff, 32'h0, 32'h0, 32'h001f00ff};
  logic [31:0] fix [8] = '{32'h0, 32'h00010001, 32'h0, 32'h0, 32'h0, 32'h80, 32'h0, 32'h100};
  // bridge bits, is io, expected downstream, address
  logic [70:0] cs [15] = '{{5'h00, 2'b11, 64'h100}, {5'h04, 2'b10, 64'h100},
    {5'h04, 2'b11, 64'h50}, {5'h04, 2'b11, 64'h10100}, {5'h00, 2'b10, 64'h203c0},
    {5'h08, 2'b11, 64'h203c0}, {5'h18, 2'b10, 64'h203c0}, {5'h1c, 2'b11, 64'h3c0},
    {5'h00, 2'b00, 64'ha0000}, {5'h08, 2'b01, 64'ha0000}, {5'h00, 2'b01, 64'h200fffff},
    {5'h00, 2'b00, 64'h20100000}, {5'h00, 2'b01, 64'h1000fffff},
    {5'h00, 2'b00, 64'h100100000}, {5'h00, 2'b00, 64'hfff00000}};
  // window nibbles and memory start are fixed; only the upper fields move
  bridge_window_config_regs bridge_window_config_regs_inst (.CLK_SYS(clk_sys),
    .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .LEGACY_MODE(legacy), .SEC_PARITY_ERR(par_err), .SYSTEM_ERROR_PIN_N(serr_n),
    .IO_ENABLE(io_en), .MEM_ENABLE(mem_en), .IO_BASE_NIBBLE(4'h0), .IO_LIMIT_NIBBLE(4'hf),
    .MEM_BASE_FIELD(12'h200), .FWD_REQ(req), .FWD_DONE(done), .FWD_DOWNSTREAM(down),
    .PARITY_RESPOND(par_resp), .ERR_MSG_REQ(err_msg), .IRQ(irq));
  cfg_host cfg_host_inst (.clk(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // pulse counts and interrupt level in one word
  task automatic ev(input logic [7:0] p, input logic [7:0] e, input logic q);
    chk({par_n[7:0], err_n[7:0], 15'h0, irq}, {p, e, 15'h0, q});
  endtask
  task automatic fwd(input logic io, input logic [63:0] a, input logic e);
    @(posedge clk_sys);
    req <= '{1'b1, io, a};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    chk({30'h0, done, down}, {30'h0, 1'b1, e});
  endtask
  // held long enough to pass the input synchronisers
  task automatic pins(input logic p, input logic s);
    @(posedge clk_sys);
    par_err <= p;
    serr_n <= ~s;
    repeat (4) @(posedge clk_sys);
    par_err <= 1'b0;
    serr_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic test_done;
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    par_n += int'(par_resp === 1'b1);
    err_n += int'(err_msg === 1'b1);
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    test_done;
  end
  // reset values, distinct patterns everywhere, then readback against masks
  initial begin
    {resetn, legacy, par_err, serr_n, io_en, mem_en, req} = {6'b000111, 66'h0};
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (ofs[i]) begin
      cfg_host_inst.cfg_rd(ofs[i], d);
      chk(d, fix[i]);
    end
    foreach (ofs[i]) cfg_host_inst.cfg_wr(ofs[i], 32'h5ac3a55c ^ {4{8'(i)}});
    foreach (ofs[i]) begin
      cfg_host_inst.cfg_rd(ofs[i], d);
      chk(d, (32'h5ac3a55c ^ {4{8'(i)}}) & msk[i] | fix[i]);
    end
    cfg_host_inst.cfg_wr(8'h40, 32'hffffffff);
    cfg_host_inst.cfg_rd(8'h40, d);
    chk(d, 32'h0);
    legacy <= 1'b1;
    repeat (6) @(posedge clk_sys);
    cfg_host_inst.cfg_rd(8'h34, d);
    chk(d, 32'h90);
    legacy <= 1'b0;
    // io window 0..1ffff, memory 20000000.., prefetch 1_00000000..1_000fffff
    cfg_host_inst.cfg_wr(8'h20, 32'h20000000);
    cfg_host_inst.cfg_wr(8'h24, 32'h0);
    cfg_host_inst.cfg_wr(8'h28, 32'h1);
    cfg_host_inst.cfg_wr(8'h2c, 32'h1);
    cfg_host_inst.cfg_wr(8'h30, 32'h10000);
    foreach (cs[i]) begin
      cfg_host_inst.cfg_wr(8'h3c, {11'h0, cs[i][70:66], 16'h0});
      fwd(cs[i][65], cs[i][63:0], cs[i][64]);
    end
    cfg_host_inst.cfg_wr(8'h3c, 32'h00080000);
    io_en <= 1'b0;
    mem_en <= 1'b0;
    fwd(1'b1, 64'h3c0, 1'b0);
    fwd(1'b0, 64'ha0000, 1'b0);
    // error events gated by the bridge bits, then mask and clear
    cfg_host_inst.cfg_rd(8'hf0, d);
    chk(d, 32'h4);
    cfg_host_inst.cfg_wr(8'hf4, 32'h7);
    cfg_host_inst.cfg_wr(8'hf8, 32'h7);
    cfg_host_inst.cfg_wr(8'h3c, 32'h0);
    pins(1'b1, 1'b1);
    cfg_host_inst.cfg_rd(8'hf0, d);
    chk(d, 32'h0);
    ev(8'h0, 8'h0, 1'b0);
    cfg_host_inst.cfg_wr(8'h3c, 32'h00030000);
    pins(1'b1, 1'b0);
    cfg_host_inst.cfg_rd(8'hf0, d);
    chk(d, 32'h1);
    ev(8'h1, 8'h0, 1'b1);
    pins(1'b0, 1'b1);
    cfg_host_inst.cfg_rd(8'hf0, d);
    chk(d, 32'h3);
    ev(8'h1, 8'h1, 1'b1);
    cfg_host_inst.cfg_wr(8'hf8, 32'h0);
    cfg_host_inst.cfg_rd(8'hf4, d);
    chk(d, 32'h0);
    ev(8'h1, 8'h1, 1'b0);
    cfg_host_inst.cfg_wr(8'hf8, 32'h7);
    cfg_host_inst.cfg_rd(8'hf8, d);
    chk(d, 32'h7);
    ev(8'h1, 8'h1, 1'b1);
    cfg_host_inst.cfg_wr(8'hf4, 32'h3);
    cfg_host_inst.cfg_rd(8'hf0, d);
    chk(d, 32'h0);
    ev(8'h1, 8'h1, 1'b0);
    test_done;
  end
endmodule
